// >>> hdl/hpfs_pkg.sv
package hpfs_pkg;

  // Data path widths and buffer depth.
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // Position of the last bit of a character.
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // Edges in one SPI byte, less one.
  localparam logic [3:0] SPI_LAST_EDGE = 4'hF;

  // Synchroniser bit positions of the pin inputs.
  localparam int SYNC_N = 8;
  localparam int SYNC_RX = 7;
  localparam int SYNC_HOLD = 6;
  localparam int SYNC_CFG = 5;
  localparam int SYNC_SLEEP = 4;
  localparam int SYNC_SS = 3;
  localparam int SYNC_SCLK = 2;
  localparam int SYNC_MOSI = 1;
  localparam int SYNC_MISO = 0;

  // Synchroniser values after reset: idle levels of each pin.
  localparam logic [7:0] SYNC_RST = 8'hE8;

  // Reset values of counters, data and status outputs.
  localparam logic [15:0] BAUD_CNT_RST = 16'h0000;
  localparam logic [7:0] SPI_DIV_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] SLAVE_FILL = 8'h00;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic NOT_READY = 1'b1;
  localparam logic NOT_LOCKED = 1'b1;

  // Serial transmitter states.
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } hpfs_utx_t;

  // Serial receiver states.
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } hpfs_urx_t;

  // SPI master states.
  typedef enum logic [2:0] {
    SM_IDLE = 3'h1,
    SM_SHIFT = 3'h2,
    SM_DONE = 3'h4
  } hpfs_spim_t;

endpackage : hpfs_pkg

// >>> hdl/hpfs_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpfs_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : hpfs_stream_if
`default_nettype wire

// >>> hdl/hpfs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module hpfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and synchronous reset, active high.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Filling and draining sides.
  hpfs_stream_if.snk in_if,
  hpfs_stream_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic wr_en;
  logic rd_en;

  // Full and empty come straight from the occupancy count.
  assign in_if.ready = (count_r != FULL_CNT);
  assign out_if.valid = (count_r != '0);
  assign out_if.data = mem_r[rd_ptr_r];
  assign wr_en = in_if.valid & in_if.ready;
  assign rd_en = out_if.valid & out_if.ready;

  // Storage is written only when there is room.
  always_ff @(posedge mclk_i) begin
    if (wr_en) begin
      mem_r[wr_ptr_r] <= in_if.data;
    end
  end

  // Pointers wrap naturally since the depth is a power of two.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      unique case ({wr_en, rd_en})
        2'b10: count_r <= count_r + 1'b1;
        2'b01: count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

  // The count never passes the depth and rises by one on a push without a pop.
  fifo_bound_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    count_r <= FULL_CNT) else $error("fifo count above depth");
  fifo_count_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_en && !rd_en) |=> count_r == $past(count_r) + 1'b1) else $error("fifo count lost a push");

endmodule : hpfs_fifo
`default_nettype wire

// >>> hdl/hpfs_top.sv
`timescale 1ns/100ps
`default_nettype none
module hpfs_top (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Configuration.
  input wire logic spi_sel_i,
  input wire logic spi_master_i,
  input wire logic [15:0] baud_div_i,
  input wire logic [7:0] spi_div_i,
  input wire logic cfg_pin_used_i,
  input wire logic sw_transparent_i,
  input wire logic sleep_status_level_i,
  input wire logic sleep_txd_level_i,
  // Network state from the radio side.
  input wire logic is_base_i,
  input wire logic hop_locked_i,
  input wire logic remote_connected_i,
  // Host pins: serial, flow control, framing and sleep.
  input wire logic serial_rx_i,
  input wire logic host_hold_n_i,
  input wire logic cfg_pin_i,
  input wire logic sleep_req_i,
  output logic serial_tx_o,
  output logic accept_ready_n_o,
  // SPI pins, each as input, output and output enable.
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // Radio side byte streams.
  output logic [7:0] radio_rx_data_o,
  output logic radio_rx_valid_o,
  input wire logic radio_rx_ready_i,
  input wire logic [7:0] radio_tx_data_i,
  input wire logic radio_tx_valid_i,
  output logic radio_tx_ready_o,
  // Status outputs.
  output logic protocol_mode_o,
  output logic activity_indicator_o,
  output logic link_locked_indicator_o
);
  logic [7:0] pins;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic rx_s, hold_s, cfg_s, sleep_s, ss_s, sclk_s, mosi_s, miso_s;
  logic sleep_q_r, wake_rst_r, rst_int;
  logic take, port_idle;
  hpfs_pkg::hpfs_utx_t utx_state_r;
  hpfs_pkg::hpfs_urx_t urx_state_r;
  hpfs_pkg::hpfs_spim_t spim_state_r;
  logic [15:0] utx_cnt_r, urx_cnt_r;
  logic [2:0] utx_bit_r, urx_bit_r, spis_cnt_r;
  logic [7:0] utx_shift_r, urx_shift_r, spim_tx_r, spim_rx_r, spis_tx_r, spis_rx_r, spis_buf_r;
  logic utx_end, urx_end, urx_done, utx_line;
  logic [7:0] spim_div_r;
  logic [3:0] spim_edge_r;
  logic spim_sclk_r, spim_done;
  logic spis_full_r, spis_sclk_q_r, spis_ss_q_r, spis_rise, spis_fall, spis_done;
  logic push_r;
  logic [7:0] push_data_r;

  hpfs_stream_if #(.W(hpfs_pkg::DATA_W)) fifo_in_if();
  hpfs_stream_if #(.W(hpfs_pkg::DATA_W)) fifo_out_if();

  // Every pin input passes two flip-flops before use.
  assign pins = {serial_rx_i, host_hold_n_i, cfg_pin_i, sleep_req_i, ss_n_i, sclk_i, mosi_i, miso_i};
  for (genvar i = 0; i < hpfs_pkg::SYNC_N; i++) begin : g_sync
    always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
        sync1_r[i] <= hpfs_pkg::SYNC_RST[i];
        sync2_r[i] <= hpfs_pkg::SYNC_RST[i];
      end else begin
        sync1_r[i] <= pins[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end
  assign rx_s = sync2_r[hpfs_pkg::SYNC_RX];
  assign hold_s = sync2_r[hpfs_pkg::SYNC_HOLD];
  assign cfg_s = sync2_r[hpfs_pkg::SYNC_CFG];
  assign sleep_s = sync2_r[hpfs_pkg::SYNC_SLEEP];
  assign ss_s = sync2_r[hpfs_pkg::SYNC_SS];
  assign sclk_s = sync2_r[hpfs_pkg::SYNC_SCLK];
  assign mosi_s = sync2_r[hpfs_pkg::SYNC_MOSI];
  assign miso_s = sync2_r[hpfs_pkg::SYNC_MISO];

  // Leaving sleep raises a one-cycle internal reset of all port logic.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sleep_q_r <= 1'b0;
      wake_rst_r <= 1'b0;
    end else begin
      sleep_q_r <= sleep_s;
      wake_rst_r <= sleep_q_r & ~sleep_s;
    end
  end
  assign rst_int = ~resetn_i | wake_rst_r;

  // A radio byte is taken only when the selected port can start it.
  assign take = radio_tx_valid_i & radio_tx_ready_o;
  assign port_idle = spi_sel_i ? (spi_master_i ? (spim_state_r == hpfs_pkg::SM_IDLE) : ~spis_full_r)
                               : ((utx_state_r == hpfs_pkg::TX_IDLE) & ~hold_s);
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      radio_tx_ready_o <= 1'b0;
    end else begin
      radio_tx_ready_o <= port_idle & ~take & ~sleep_s;
    end
  end

  // Serial transmitter; hold is looked at only before a start bit.
  assign utx_end = (utx_cnt_r == baud_div_i - 16'h0001);
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      utx_state_r <= hpfs_pkg::TX_IDLE;
      utx_cnt_r <= hpfs_pkg::BAUD_CNT_RST;
      utx_bit_r <= hpfs_pkg::FIRST_BIT;
      utx_shift_r <= hpfs_pkg::BYTE_RST;
    end else begin
      utx_cnt_r <= (utx_state_r == hpfs_pkg::TX_IDLE || utx_end) ? hpfs_pkg::BAUD_CNT_RST
                                                                  : utx_cnt_r + 16'h0001;
      unique case (utx_state_r)
        hpfs_pkg::TX_IDLE: begin
          if (take && !spi_sel_i) begin
            utx_shift_r <= radio_tx_data_i;
            utx_state_r <= hpfs_pkg::TX_START;
          end
        end
        hpfs_pkg::TX_START: begin
          if (utx_end) begin
            utx_bit_r <= hpfs_pkg::FIRST_BIT;
            utx_state_r <= hpfs_pkg::TX_DATA;
          end
        end
        hpfs_pkg::TX_DATA: begin
          if (utx_end) begin
            utx_shift_r <= {1'b0, utx_shift_r[7:1]};
            utx_bit_r <= utx_bit_r + 3'h1;
            if (utx_bit_r == hpfs_pkg::LAST_BIT) begin
              utx_state_r <= hpfs_pkg::TX_STOP;
            end
          end
        end
        hpfs_pkg::TX_STOP: begin
          if (utx_end) begin
            utx_state_r <= hpfs_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end
  assign utx_line = (utx_state_r == hpfs_pkg::TX_START) ? 1'b0 :
                    (utx_state_r == hpfs_pkg::TX_DATA) ? utx_shift_r[0] : hpfs_pkg::LINE_IDLE;

  // Serial receiver samples each bit in its middle.
  assign urx_end = (urx_cnt_r == baud_div_i - 16'h0001);
  assign urx_done = (urx_state_r == hpfs_pkg::RX_STOP) & urx_end & rx_s;
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      urx_state_r <= hpfs_pkg::RX_IDLE;
      urx_cnt_r <= hpfs_pkg::BAUD_CNT_RST;
      urx_bit_r <= hpfs_pkg::FIRST_BIT;
      urx_shift_r <= hpfs_pkg::BYTE_RST;
    end else begin
      urx_cnt_r <= urx_cnt_r + 16'h0001;
      unique case (urx_state_r)
        hpfs_pkg::RX_IDLE: begin
          urx_cnt_r <= hpfs_pkg::BAUD_CNT_RST;
          if (!rx_s && !spi_sel_i && !sleep_s) begin
            urx_state_r <= hpfs_pkg::RX_START;
          end
        end
        hpfs_pkg::RX_START: begin
          if (urx_cnt_r == {1'b0, baud_div_i[15:1]}) begin
            urx_cnt_r <= hpfs_pkg::BAUD_CNT_RST;
            urx_bit_r <= hpfs_pkg::FIRST_BIT;
            urx_state_r <= rx_s ? hpfs_pkg::RX_IDLE : hpfs_pkg::RX_DATA;
          end
        end
        hpfs_pkg::RX_DATA: begin
          if (urx_end) begin
            urx_cnt_r <= hpfs_pkg::BAUD_CNT_RST;
            urx_shift_r <= {rx_s, urx_shift_r[7:1]};
            urx_bit_r <= urx_bit_r + 3'h1;
            if (urx_bit_r == hpfs_pkg::LAST_BIT) begin
              urx_state_r <= hpfs_pkg::RX_STOP;
            end
          end
        end
        hpfs_pkg::RX_STOP: begin
          if (urx_end) begin
            urx_state_r <= hpfs_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // SPI master, mode 0: sample on the rising edge, shift on the falling edge.
  assign spim_done = (spim_state_r == hpfs_pkg::SM_DONE);
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      spim_state_r <= hpfs_pkg::SM_IDLE;
      spim_div_r <= hpfs_pkg::SPI_DIV_RST;
      spim_edge_r <= '0;
      spim_sclk_r <= 1'b0;
      spim_tx_r <= hpfs_pkg::BYTE_RST;
      spim_rx_r <= hpfs_pkg::BYTE_RST;
    end else begin
      unique case (spim_state_r)
        hpfs_pkg::SM_IDLE: begin
          spim_sclk_r <= 1'b0;
          spim_div_r <= hpfs_pkg::SPI_DIV_RST;
          spim_edge_r <= '0;
          if (take && spi_sel_i && spi_master_i) begin
            spim_tx_r <= radio_tx_data_i;
            spim_state_r <= hpfs_pkg::SM_SHIFT;
          end
        end
        hpfs_pkg::SM_SHIFT: begin
          spim_div_r <= spim_div_r + 8'h01;
          if (spim_div_r == spi_div_i) begin
            spim_div_r <= hpfs_pkg::SPI_DIV_RST;
            spim_sclk_r <= ~spim_sclk_r;
            spim_edge_r <= spim_edge_r + 4'h1;
            if (!spim_sclk_r) begin
              spim_rx_r <= {spim_rx_r[6:0], miso_s};
            end else begin
              spim_tx_r <= {spim_tx_r[6:0], 1'b0};
            end
            if (spim_edge_r == hpfs_pkg::SPI_LAST_EDGE) begin
              spim_state_r <= hpfs_pkg::SM_DONE;
            end
          end
        end
        hpfs_pkg::SM_DONE: begin
          spim_state_r <= hpfs_pkg::SM_IDLE;
        end
      endcase
    end
  end

  // SPI slave: selected while the select input is low.
  assign spis_rise = sclk_s & ~spis_sclk_q_r;
  assign spis_fall = ~sclk_s & spis_sclk_q_r;
  assign spis_done = spis_rise & ~ss_s & (spis_cnt_r == hpfs_pkg::LAST_BIT) & spi_sel_i & ~spi_master_i;
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      spis_sclk_q_r <= 1'b0;
      spis_ss_q_r <= 1'b1;
      spis_cnt_r <= hpfs_pkg::FIRST_BIT;
      spis_rx_r <= hpfs_pkg::BYTE_RST;
      spis_tx_r <= hpfs_pkg::SLAVE_FILL;
      spis_buf_r <= hpfs_pkg::BYTE_RST;
      spis_full_r <= 1'b0;
    end else begin
      spis_sclk_q_r <= sclk_s;
      spis_ss_q_r <= ss_s;
      if ((spis_ss_q_r && !ss_s) || (!ss_s && spis_fall && spis_cnt_r == hpfs_pkg::FIRST_BIT)) begin
        spis_tx_r <= spis_full_r ? spis_buf_r : hpfs_pkg::SLAVE_FILL;
        spis_full_r <= 1'b0;
      end else if (!ss_s && spis_fall) begin
        spis_tx_r <= {spis_tx_r[6:0], 1'b0};
      end
      if (spis_ss_q_r && !ss_s) begin
        spis_cnt_r <= hpfs_pkg::FIRST_BIT;
      end else if (!ss_s && spis_rise) begin
        spis_rx_r <= {spis_rx_r[6:0], mosi_s};
        spis_cnt_r <= spis_cnt_r + 3'h1;
      end
      // A new byte from the radio side wins over the reload that frees the buffer.
      if (take && spi_sel_i && !spi_master_i) begin
        spis_buf_r <= radio_tx_data_i;
        spis_full_r <= 1'b1;
      end
    end
  end

  // Received bytes go to the buffer; a byte sent while full is dropped.
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      push_r <= 1'b0;
      push_data_r <= hpfs_pkg::BYTE_RST;
    end else begin
      push_r <= urx_done | spim_done | spis_done;
      push_data_r <= urx_done ? urx_shift_r : spim_done ? spim_rx_r : {spis_rx_r[6:0], mosi_s};
    end
  end
  assign fifo_in_if.valid = push_r;
  assign fifo_in_if.data = push_data_r;

  hpfs_fifo #(.WIDTH(hpfs_pkg::DATA_W), .DEPTH(hpfs_pkg::FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .srst_i(rst_int),
    .in_if(fifo_in_if),
    .out_if(fifo_out_if)
  );

  // Output stage keeps the radio side stream registered.
  assign fifo_out_if.ready = ~radio_rx_valid_o | radio_rx_ready_i;
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      radio_rx_valid_o <= 1'b0;
      radio_rx_data_o <= hpfs_pkg::BYTE_RST;
    end else if (fifo_out_if.ready) begin
      radio_rx_valid_o <= fifo_out_if.valid;
      radio_rx_data_o <= fifo_out_if.data;
    end
  end

  // SPI pins: master drives select, clock and data out; slave drives MISO when selected.
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      ss_n_o <= 1'b1;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      ss_n_oe_n_o <= 1'b1;
      sclk_oe_n_o <= 1'b1;
      mosi_oe_n_o <= 1'b1;
      miso_oe_n_o <= 1'b1;
    end else begin
      ss_n_o <= (spim_state_r != hpfs_pkg::SM_SHIFT);
      sclk_o <= spim_sclk_r;
      mosi_o <= spim_tx_r[7];
      miso_o <= spis_tx_r[7];
      ss_n_oe_n_o <= ~(spi_sel_i & spi_master_i);
      sclk_oe_n_o <= ~(spi_sel_i & spi_master_i);
      mosi_oe_n_o <= ~(spi_sel_i & spi_master_i);
      miso_oe_n_o <= ~(spi_sel_i & ~spi_master_i & ~ss_s);
    end
  end

  // Host facing status and serial line; serial line, accept-ready and lock indicator take sleep levels from configuration.
  always_ff @(posedge mclk_i) begin
    if (rst_int) begin
      serial_tx_o <= hpfs_pkg::LINE_IDLE;
      accept_ready_n_o <= hpfs_pkg::NOT_READY;
      link_locked_indicator_o <= hpfs_pkg::NOT_LOCKED;
      activity_indicator_o <= 1'b0;
      protocol_mode_o <= 1'b0;
    end else begin
      serial_tx_o <= sleep_s ? sleep_txd_level_i : utx_line;
      accept_ready_n_o <= sleep_s ? sleep_status_level_i : ~fifo_in_if.ready;
      link_locked_indicator_o <= sleep_s ? sleep_status_level_i :
                                 ~(is_base_i ? remote_connected_i : hop_locked_i);
      activity_indicator_o <= (utx_state_r != hpfs_pkg::TX_IDLE) | (urx_state_r != hpfs_pkg::RX_IDLE) |
                              (spim_state_r != hpfs_pkg::SM_IDLE) |
                              (spi_sel_i & ~spi_master_i & ~ss_s);
      protocol_mode_o <= cfg_pin_used_i ? ~cfg_s : ~sw_transparent_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_int);

  sequence wake_edge_s;
    sleep_q_r && !sleep_s;
  endsequence
  sequence wake_pulse_s;
    wake_rst_r ##1 !wake_rst_r;
  endsequence

  tx_hold_gate_a: assert property ((utx_state_r == hpfs_pkg::TX_START &&
    $past(utx_state_r) == hpfs_pkg::TX_IDLE) |-> !$past(hold_s, 2)) else $error("start bit while held");
  char_whole_a: assert property ((utx_state_r == hpfs_pkg::TX_DATA && hold_s && !utx_end) |=>
    utx_state_r == hpfs_pkg::TX_DATA) else $error("character cut by hold");
  ready_full_a: assert property ((!sleep_s && !fifo_in_if.ready) |=> accept_ready_n_o)
    else $error("accept-ready low while full");
  framing_sel_a: assert property (1'b1 |=> protocol_mode_o ==
    $past(cfg_pin_used_i ? ~cfg_s : ~sw_transparent_i)) else $error("wrong framing mode");
  activity_tx_a: assert property ((utx_state_r != hpfs_pkg::TX_IDLE) |=> activity_indicator_o)
    else $error("activity low while sending");
  remote_lock_a: assert property ((!sleep_s && !is_base_i && hop_locked_i) |=> !link_locked_indicator_o)
    else $error("locked remote shows unlocked");
  base_lock_a: assert property ((!sleep_s && is_base_i) |=>
    link_locked_indicator_o == !$past(remote_connected_i)) else $error("base lock level wrong");
  sleep_status_a: assert property (sleep_s |=> (link_locked_indicator_o == $past(sleep_status_level_i)) &&
    (accept_ready_n_o == $past(sleep_status_level_i))) else $error("sleep status level wrong");
  sleep_txd_a: assert property (sleep_s |=> serial_tx_o == $past(sleep_txd_level_i))
    else $error("sleep serial level wrong");
  master_sel_a: assert property ((spi_sel_i && spi_master_i && spim_state_r == hpfs_pkg::SM_SHIFT) |=>
    !ss_n_o && !ss_n_oe_n_o && !sclk_oe_n_o) else $error("master not selecting");
  slave_miso_a: assert property ((spi_sel_i && !spi_master_i) |=> mosi_oe_n_o && sclk_oe_n_o &&
    (miso_oe_n_o == $past(ss_s))) else $error("slave pin direction wrong");
  wake_reset_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wake_edge_s |=> wake_pulse_s) else $error("no reset after wake");
  hw_reset_a: assert property (@(posedge mclk_i) disable iff (1'b0) !resetn_i |=>
    utx_state_r == hpfs_pkg::TX_IDLE && accept_ready_n_o && !radio_tx_ready_o) else $error("reset ignored");

endmodule : hpfs_top
`default_nettype wire

// >>> verif/hpfs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hpfs_host_model #(
  parameter int BAUD = 4
) (
  // Clock and host pins.
  input wire logic mclk_i,
  input wire logic dev_tx_i,
  input wire logic accept_ready_n_i,
  input wire logic dev_miso_i,
  output logic host_tx_o,
  output logic host_ss_n_o,
  output logic host_sclk_o,
  output logic host_mosi_o
);
  logic [7:0] got_q[$];
  logic [9:0] fr;
  int w;
  logic stuck = 1'b0;
  // Host lines start idle: serial high, SPI deselected with the clock low.
  initial begin
    host_tx_o = 1'b1;
    host_ss_n_o = 1'b1;
    host_sclk_o = 1'b0;
    host_mosi_o = 1'b0;
  end
  // Waits a bounded time until the device says it can take data; a timeout is remembered.
  task automatic wait_ready;
    w = 0;
    while (accept_ready_n_i !== 1'b0 && w < 2000) begin
      @(posedge mclk_i);
      w++;
    end
    if (w >= 2000) stuck = 1'b1;
  endtask : wait_ready
  // Sends one 8N1 character once the device says it can take it or the bounded wait times out.
  task automatic send(input logic [7:0] b);
    wait_ready();
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_tx_o <= fr[i];
      repeat (BAUD) @(posedge mclk_i);
    end
  endtask : send
  // One SPI mode 0 byte as master, MSB first, slow enough for the device's synchronisers.
  task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] mi);
    wait_ready();
    host_ss_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      host_mosi_o <= mo[i];
      repeat (8) @(posedge mclk_i);
      host_sclk_o <= 1'b1;
      mi[i] = dev_miso_i;
      repeat (8) @(posedge mclk_i);
      host_sclk_o <= 1'b0;
    end
    repeat (8) @(posedge mclk_i);
    host_ss_n_o <= 1'b1;
  endtask : spi_xfer
  // Decodes characters from the device, sampling each bit in its middle.
  always begin : rx_proc
    logic [7:0] b;
    @(negedge dev_tx_i);
    repeat (BAUD + BAUD / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = dev_tx_i;
      repeat (BAUD) @(posedge mclk_i);
    end
    got_q.push_back(b);
  end
endmodule : hpfs_host_model
`default_nettype wire

// >>> verif/hpfs_test.sv
`timescale 1ns/100ps
`default_nettype none
module hpfs_test;
  localparam int BAUD = 4;
  // Design inputs, each with a value at time zero.
  logic mclk_i = 1'b0, resetn_i = 1'b0, spi_sel_i = 1'b0, spi_master_i = 1'b0;
  logic [15:0] baud_div_i = 16'h0004;
  logic [7:0] spi_div_i = 8'h01, radio_tx_data_i = 8'h00, radio_rx_data_o;
  logic cfg_pin_used_i = 1'b0, sw_transparent_i = 1'b1, sleep_status_level_i = 1'b0;
  logic sleep_txd_level_i = 1'b0, is_base_i = 1'b0, hop_locked_i = 1'b0, serial_rx_i;
  logic remote_connected_i = 1'b0, host_hold_n_i = 1'b0, cfg_pin_i = 1'b1;
  logic sleep_req_i = 1'b0, miso_i = 1'b1, ss_n_i, sclk_i, mosi_i;
  logic radio_rx_ready_i = 1'b0, radio_tx_valid_i = 1'b0;
  // Design outputs.
  logic serial_tx_o, accept_ready_n_o, ss_n_o, ss_n_oe_n_o, sclk_o, sclk_oe_n_o, mosi_o;
  logic mosi_oe_n_o, miso_o, miso_oe_n_o, radio_rx_valid_o, radio_tx_ready_o;
  logic protocol_mode_o, activity_indicator_o, link_locked_indicator_o;
  logic [15:0] rnd = 16'h24D8;
  logic [7:0] exp_q[$], txe_q[$], got;
  int n_errors = 0, cmp_count = 0, n;

  hpfs_top dut (.*);
  hpfs_host_model #(.BAUD(BAUD)) host (.mclk_i(mclk_i), .dev_tx_i(serial_tx_o),
    .accept_ready_n_i(accept_ready_n_o), .dev_miso_i(miso_o), .host_tx_o(serial_rx_i),
    .host_ss_n_o(ss_n_i), .host_sclk_o(sclk_i), .host_mosi_o(mosi_i));

  // Clock of 100 ns period.
  initial forever #50 mclk_i = ~mclk_i;

  // Next value of the stimulus shift register.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Compares a seen value with the expected one and reports a mismatch.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // Offers one byte to the transmit stream and waits until it is taken.
  task automatic tx_byte(input logic [7:0] b);
    @(posedge mclk_i);
    radio_tx_data_i <= b;
    radio_tx_valid_i <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (radio_tx_ready_o !== 1'b1 && n < 500);
    if (n >= 500) begin
      n_errors++;
      stop_test();
    end
    @(posedge mclk_i);
    radio_tx_valid_i <= 1'b0;
  endtask : tx_byte

  // Every byte handed to the radio side must be the next one expected.
  always @(posedge mclk_i) begin
    if (radio_rx_valid_o === 1'b1 && radio_rx_ready_i === 1'b1)
      check(radio_rx_data_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    check(serial_tx_o, 1'b1);
    check(accept_ready_n_o, 1'b1);
    check(link_locked_indicator_o, 1'b1);
    check(activity_indicator_o, 1'b0);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (10) @(negedge mclk_i);
    // Random framing and network state.
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk_i);
      rnd = lfsr(rnd);
      {sleep_txd_level_i, is_base_i, hop_locked_i, remote_connected_i} <= rnd[3:0];
      {cfg_pin_used_i, cfg_pin_i, sw_transparent_i} <= rnd[6:4];
      repeat (5) @(negedge mclk_i);
      check(link_locked_indicator_o, is_base_i ? !remote_connected_i : !hop_locked_i);
      check(protocol_mode_o, cfg_pin_used_i ? !cfg_pin_i : !sw_transparent_i);
    end
    // Fill the buffer from the host until the device refuses more.
    check(accept_ready_n_o, 1'b0);
    for (int i = 0; i < 33; i++) begin
      rnd = lfsr(rnd);
      exp_q.push_back(rnd[7:0]);
      fork
        host.send(rnd[7:0]);
        begin
          repeat (20) @(negedge mclk_i);
          check(activity_indicator_o, 1'b1);
        end
      join
    end
    repeat (20) @(negedge mclk_i);
    check(accept_ready_n_o, 1'b1);
    check(activity_indicator_o, 1'b0);
    @(posedge mclk_i);
    radio_rx_ready_i <= 1'b1;
    repeat (80) @(negedge mclk_i);
    check(8'(exp_q.size()), 8'h00);
    check(accept_ready_n_o, 1'b0);
    // Back-to-back bytes to the host.
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      txe_q.push_back(rnd[7:0]);
      tx_byte(rnd[7:0]);
    end
    // A byte offered while the host holds off, then a hold raised mid-character.
    @(posedge mclk_i);
    host_hold_n_i <= 1'b1;
    rnd = lfsr(rnd);
    txe_q.push_back(rnd[7:0]);
    fork
      tx_byte(rnd[7:0]);
      begin
        repeat (80) @(negedge mclk_i);
        check(8'(host.got_q.size()), 8'h06);
        check(radio_tx_ready_o, 1'b0);
        @(posedge mclk_i);
        host_hold_n_i <= 1'b0;
      end
    join
    repeat (3 * BAUD) @(posedge mclk_i);
    host_hold_n_i <= 1'b1;
    repeat (12 * BAUD) @(negedge mclk_i);
    for (int i = 0; i < 7; i++)
      check(host.got_q.size() > i ? host.got_q[i] : 8'hXX, txe_q[i]);
    @(posedge mclk_i);
    host_hold_n_i <= 1'b0;
    // Sleep with a byte waiting, then wake.
    radio_rx_ready_i <= 1'b0;
    rnd = lfsr(rnd);
    sleep_status_level_i <= rnd[0];
    host.send(rnd[15:8]);
    repeat (10) @(negedge mclk_i);
    @(posedge mclk_i);
    sleep_req_i <= 1'b1;
    repeat (6) @(negedge mclk_i);
    check(accept_ready_n_o, sleep_status_level_i);
    check(link_locked_indicator_o, sleep_status_level_i);
    check(serial_tx_o, sleep_txd_level_i);
    @(posedge mclk_i);
    sleep_req_i <= 1'b0;
    repeat (60) @(negedge mclk_i);
    check(radio_rx_valid_o, 1'b0);
    check(serial_tx_o, 1'b1);
    // One transfer as SPI master; the peripheral answers all ones.
    @(posedge mclk_i);
    spi_sel_i <= 1'b1;
    spi_master_i <= 1'b1;
    radio_rx_ready_i <= 1'b1;
    exp_q.push_back(8'hFF);
    fork
      tx_byte(rnd[7:0]);
      begin
        repeat (12) @(negedge mclk_i);
        check(ss_n_o, 1'b0);
        check({ss_n_oe_n_o, sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 8'h01);
        check(activity_indicator_o, 1'b1);
      end
    join
    repeat (100) @(negedge mclk_i);
    check(8'(exp_q.size()), 8'h00);
    check(ss_n_o, 1'b1);
    // One transfer as SPI slave: the radio byte goes out on MISO, the host byte comes in.
    @(posedge mclk_i);
    spi_master_i <= 1'b0;
    rnd = lfsr(rnd);
    exp_q.push_back(rnd[15:8]);
    tx_byte(rnd[7:0]);
    fork
      host.spi_xfer(rnd[15:8], got);
      begin
        repeat (40) @(negedge mclk_i);
        check({miso_oe_n_o, mosi_oe_n_o, activity_indicator_o}, 8'h03);
      end
    join
    check(got, rnd[7:0]);
    repeat (20) @(negedge mclk_i);
    check(8'(exp_q.size()), 8'h00);
    check(host.stuck, 1'b0);
    stop_test();
  end
endmodule : hpfs_test
`default_nettype wire
